// File: design/pplc_regs.svh
// Setting codes, scale factors and timing counts of the process loop controller
`ifndef PPLC_REGS_SVH
`define PPLC_REGS_SVH

// Loop enable mode codes
`define PPLC_EN_OFF      2'h0
`define PPLC_EN_ALWAYS   2'h1
`define PPLC_EN_EXT      2'h2

// Set point source codes
`define PPLC_SRC_DIGITAL 2'h0
`define PPLC_SRC_VOLT    2'h1
`define PPLC_SRC_CURR    2'h2

// Feedback source codes
`define PPLC_FB_VOLT     2'h0
`define PPLC_FB_CURR     2'h1
`define PPLC_FB_V_MINUS  2'h2
`define PPLC_FB_C_MINUS  2'h3

// Timing: core clock and computation interval
`define PPLC_CLK_HZ      50000000
`define PPLC_CALC_MS     10
`define PPLC_CALC_CYCLES (`PPLC_CLK_HZ / 1000 * `PPLC_CALC_MS)
`define PPLC_SBY_UNIT_MS 100
`define PPLC_SBY_TICKS   (`PPLC_SBY_UNIT_MS / `PPLC_CALC_MS)

// Scale factors between setting units
`define PPLC_PCT_FS      10000
`define PPLC_LIM_SCALE   10
`define PPLC_WAKE_SCALE  1000
`define PPLC_TI_SCALE    10
`define PPLC_GAIN_DIV    10

`endif

// File: design/pplc_pkg.sv
// Shared types of the process loop controller
package pplc_pkg;

  typedef enum logic [1:0] {
    PPLC_IDLE,
    PPLC_RUN,
    PPLC_CALC,
    PPLC_STANDBY
  } pplc_state_e;

  // Process values in 0.01 % of full scale, signed for difference feedback
  typedef logic signed [17:0] pplc_pct_t;

endpackage : pplc_pkg

// File: design/pplc_div.sv
// Serial restoring divider used for the loop correction
`timescale 1ns/1ps
module pplc_div #(
  parameter int NW = 64,
  parameter int DW = 32
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_start,
  input  wire logic [NW-1:0] i_num,
  input  wire logic [DW-1:0] i_den,
  output logic               o_done,
  output logic [NW-1:0]      o_quot
);

  localparam int CW = $clog2(NW + 1);

  if (NW < 2 || DW < 2) begin : g_chk
    $error("pplc_div widths too small");
  end

  typedef struct packed {
    logic          busy;
    logic          done;
    logic [CW-1:0] cnt;
    logic [NW-1:0] quo;
    logic [DW:0]   rem;
    logic [DW-1:0] den;
  } pplc_div_s;

  pplc_div_s q;
  pplc_div_s d;

  // One quotient bit per cycle; a zero divisor yields all ones
  always_comb begin
    logic [DW:0] r;
    r = '0;
    d = q;
    d.done = 1'b0;
    if (i_start) begin
      d.busy = 1'b1;
      d.cnt  = CW'(NW);
      d.quo  = i_num;
      d.rem  = '0;
      d.den  = i_den;
    end else if (q.busy) begin
      r = {q.rem[DW-1:0], q.quo[NW-1]};
      d.quo = {q.quo[NW-2:0], 1'b0};
      if (r >= {1'b0, q.den}) begin
        r = r - {1'b0, q.den};
        d.quo[0] = 1'b1;
      end
      d.rem = r;
      d.cnt = q.cnt - 1'b1;
      if (q.cnt == CW'(1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_done = q.done;
  assign o_quot = q.quo;

endmodule : pplc_div

// File: design/pplc_loop_ctrl.sv
// Process loop controller: set point, feedback, incremental loop, alarms, standby
//
// Functional notes
// - Mode 0 off, mode 1 always enabled
// - Mode 2 runs only while external start high
// - Negative mode: feedback above set point raises frequency
// - Set point from digital, voltage or current
// - Feedback voltage, current, or either difference
// - Digital 100 percent equals analog full scale
// - Upper alarm when feedback exceeds upper limit
// - Lower alarm when feedback below lower limit
// - One increment computed every 10 ms
// - Increment clamped to maximum step setting
// - Narrower proportional band gives higher gain
// - Shorter integral time accumulates faster
// - Longer derivative time reacts more to changes
// - Low frequency starts standby timing
// - Low too long: stop output, suspend loop
// - In standby, wake when feedback below threshold
// - Wake threshold is percentage of set point
`timescale 1ns/1ps
`include "pplc_regs.svh"
module pplc_loop_ctrl import pplc_pkg::*; #(
  parameter int          ADC_W       = 12,
  parameter int          FREQ_W      = 16,
  parameter int unsigned CALC_CYCLES = `PPLC_CALC_CYCLES
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rstn,
  input  wire logic [1:0]        i_loop_enable_mode,
  input  wire logic              i_feedback_polarity,
  input  wire logic [1:0]        i_setpoint_source,
  input  wire logic [1:0]        i_feedback_source,
  input  wire logic [13:0]       i_digital_target,
  input  wire logic [9:0]        i_upper_alarm_limit,
  input  wire logic [9:0]        i_lower_alarm_limit,
  input  wire logic [11:0]       i_proportional_band,
  input  wire logic [11:0]       i_integral_time,
  input  wire logic [11:0]       i_derivative_time,
  input  wire logic [6:0]        i_max_step_increment,
  input  wire logic [FREQ_W-1:0] i_standby_freq_threshold,
  input  wire logic [11:0]       i_standby_delay,
  input  wire logic [9:0]        i_wakeup_threshold,
  input  wire logic [FREQ_W-1:0] i_max_freq,
  input  wire logic [ADC_W-1:0]  i_voltage_analog_input,
  input  wire logic [ADC_W-1:0]  i_current_analog_input,
  input  wire logic              i_ext_start,
  output logic [FREQ_W-1:0]      o_freq_cmd,
  output logic signed [FREQ_W:0] o_freq_step,
  output logic                   o_run,
  output logic                   o_loop_active,
  output logic                   o_standby,
  output logic                   o_upper_alarm,
  output logic                   o_lower_alarm
);

  localparam int          TW        = $clog2(CALC_CYCLES);
  localparam logic [TW-1:0] TICK_LAST = TW'(CALC_CYCLES - 1);
  localparam logic [31:0] ADC_MAX   = 32'((1 << ADC_W) - 1);
  localparam logic [3:0]  SBY_LAST  = 4'(`PPLC_SBY_TICKS - 1);

  // The divider must finish well inside one computation interval
  if (ADC_W < 4 || ADC_W > 16 || FREQ_W < 8 || FREQ_W > 24
      || CALC_CYCLES < 80) begin : g_chk
    $error("pplc_loop_ctrl parameters out of range");
  end

  typedef struct packed {
    logic [2:0]           sync;
    logic                 ext;
    pplc_state_e          st;
    logic [TW-1:0]        tick;
    logic                 go;
    pplc_pct_t            e_now;
    pplc_pct_t            e1;
    pplc_pct_t            e2;
    logic [FREQ_W-1:0]    freq;
    logic signed [FREQ_W:0] step;
    logic [3:0]           sub;
    logic [11:0]          low_time;
    logic                 up_al;
    logic                 lo_al;
    logic                 act;
    logic                 sby;
    logic                 run;
  } pplc_core_s;

  pplc_core_s q;
  pplc_core_s d;

  // Analog code to 0.01 % of full scale; full scale is 100.00 %
  function automatic pplc_pct_t pct_of(input logic [ADC_W-1:0] c);
    logic [31:0] t;
    t = 32'(c) * 32'(`PPLC_PCT_FS) / ADC_MAX;
    return $signed(t[17:0]);
  endfunction : pct_of

  // Sign-extend a process value for the wide loop arithmetic
  function automatic logic signed [63:0] sx(input pplc_pct_t v);
    return 64'(v);
  endfunction : sx

  // Zero-extend a setting for the wide loop arithmetic
  function automatic logic signed [63:0] ux(input logic [23:0] v);
    return $signed({40'h0, v});
  endfunction : ux

  pplc_pct_t           sp;
  pplc_pct_t           fb;
  pplc_pct_t           err;
  logic signed [63:0]  inner;
  logic signed [63:0]  num_s;
  logic signed [63:0]  den_s;
  logic [63:0]         num_mag;
  logic [31:0]         den_mag;
  logic                div_done;
  logic [63:0]         div_quot;

  // Set point and feedback selection
  always_comb begin
    case (i_setpoint_source)
      `PPLC_SRC_VOLT: sp = pct_of(i_voltage_analog_input);
      `PPLC_SRC_CURR: sp = pct_of(i_current_analog_input);
      default:        sp = $signed({4'h0, i_digital_target});
    endcase
    case (i_feedback_source)
      `PPLC_FB_CURR:    fb = pct_of(i_current_analog_input);
      `PPLC_FB_V_MINUS: fb = pct_of(i_voltage_analog_input)
                             - pct_of(i_current_analog_input);
      `PPLC_FB_C_MINUS: fb = pct_of(i_current_analog_input)
                             - pct_of(i_voltage_analog_input);
      default:          fb = pct_of(i_voltage_analog_input);
    endcase
    // Deviation sign chooses the correction direction
    err = i_feedback_polarity ? (fb - sp) : (sp - fb);
  end

  // Incremental loop: 1000/PB * (de + e*T/Ti + Td/T*dde), scaled to 0.01 Hz
  always_comb begin
    logic signed [63:0] de;
    logic signed [63:0] dde;
    logic signed [63:0] ti10;
    logic signed [63:0] pb;
    de    = sx(q.e_now) - sx(q.e1);
    dde   = sx(q.e_now) - 64'sh2 * sx(q.e1) + sx(q.e2);
    ti10  = ux(24'(i_integral_time)) * 64'(`PPLC_TI_SCALE);
    // A zero band would divide by zero; treat it as the narrowest band
    pb    = (i_proportional_band == 12'h000) ? 64'sh1 : ux(24'(i_proportional_band));
    inner = de + ux(24'(i_derivative_time)) * dde;
    den_s = pb * 64'(`PPLC_GAIN_DIV);
    // Zero integral time disables the integral action
    if (i_integral_time != 12'h000) begin
      inner = ti10 * inner + sx(q.e_now);
      den_s = den_s * ti10;
    end
    num_s   = inner * ux(24'(i_max_freq));
    num_mag = (num_s < 0) ? 64'(-num_s) : 64'(num_s);
    den_mag = den_s[31:0];
  end

  pplc_div #(
    .NW (64),
    .DW (32)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .i_start    (q.go),
    .i_num      (num_mag),
    .i_den      (den_mag),
    .o_done     (div_done),
    .o_quot     (div_quot)
  );

  // Next-state logic of the whole controller
  always_comb begin
    logic                   enable;
    logic [63:0]            mag;
    logic signed [FREQ_W+1:0] f_new;
    logic signed [63:0]     wake_lhs;
    logic signed [63:0]     wake_rhs;
    enable   = 1'b0;
    mag      = '0;
    f_new    = '0;
    wake_lhs = '0;
    wake_rhs = '0;
    d = q;
    d.go = 1'b0;

    // Start pin: three stages, a change counts once the last two agree
    d.sync = {q.sync[1:0], i_ext_start};
    if (q.sync[1] == q.sync[2]) begin
      d.ext = q.sync[2];
    end

    case (i_loop_enable_mode)
      `PPLC_EN_ALWAYS: enable = 1'b1;
      `PPLC_EN_EXT:    enable = q.ext;
      default:         enable = 1'b0;
    endcase

    // Alarms follow feedback in every state
    d.up_al = sx(fb) > ux(24'(i_upper_alarm_limit)) * 64'(`PPLC_LIM_SCALE);
    d.lo_al = sx(fb) < ux(24'(i_lower_alarm_limit)) * 64'(`PPLC_LIM_SCALE);

    // Interval timer runs only while the loop is live
    if (q.st == PPLC_RUN || q.st == PPLC_CALC) begin
      d.tick = (q.tick == TICK_LAST) ? '0 : q.tick + 1'b1;
    end else begin
      d.tick = '0;
    end

    // Wake threshold relative to set point, no division needed
    wake_lhs = sx(fb) * 64'(`PPLC_WAKE_SCALE);
    wake_rhs = ux(24'(i_wakeup_threshold)) * sx(sp);

    case (q.st)
      PPLC_IDLE: begin
        d.freq     = '0;
        d.step     = '0;
        d.e1       = '0;
        d.e2       = '0;
        d.sub      = '0;
        d.low_time = '0;
        if (enable) begin
          d.st = PPLC_RUN;
        end
      end
      PPLC_RUN: begin
        if (!enable) begin
          d.st = PPLC_IDLE;
        end else if (q.tick == TICK_LAST) begin
          d.e_now = err;
          d.go    = 1'b1;
          d.st    = PPLC_CALC;
        end
      end
      PPLC_CALC: begin
        if (!enable) begin
          d.st = PPLC_IDLE;
        end else if (div_done) begin
          // Limit the magnitude, then restore the sign
          mag = (div_quot > 64'(i_max_step_increment))
                ? 64'(i_max_step_increment) : div_quot;
          d.step = (num_s < 0) ? -$signed({1'b0, mag[FREQ_W-1:0]})
                               : $signed({1'b0, mag[FREQ_W-1:0]});
          f_new = $signed({2'b00, q.freq}) + (FREQ_W+2)'(d.step);
          // Frequency command never leaves the 0..max window
          if (f_new < 0) begin
            f_new = '0;
          end else if (f_new > $signed({2'b00, i_max_freq})) begin
            f_new = $signed({2'b00, i_max_freq});
          end
          d.freq = f_new[FREQ_W-1:0];
          d.e2   = q.e1;
          d.e1   = q.e_now;
          d.st   = PPLC_RUN;
          // Low-frequency time measured in 0.1 s units
          if (f_new[FREQ_W-1:0] < i_standby_freq_threshold) begin
            if (q.sub == SBY_LAST) begin
              d.sub = '0;
              if (q.low_time != 12'hfff) begin
                d.low_time = q.low_time + 1'b1;
              end
            end else begin
              d.sub = q.sub + 1'b1;
            end
            if (q.low_time > i_standby_delay) begin
              d.st   = PPLC_STANDBY;
              d.freq = '0;
              d.step = '0;
            end
          end else begin
            d.sub      = '0;
            d.low_time = '0;
          end
        end
      end
      PPLC_STANDBY: begin
        d.freq = '0;
        d.step = '0;
        if (!enable) begin
          d.st = PPLC_IDLE;
        end else if (wake_lhs < wake_rhs) begin
          // Restart with clean history so no stale derivative kicks
          d.st       = PPLC_RUN;
          d.e1       = '0;
          d.e2       = '0;
          d.sub      = '0;
          d.low_time = '0;
        end
      end
      default: begin
        d.st = PPLC_IDLE;
      end
    endcase

    d.act = (d.st == PPLC_RUN) || (d.st == PPLC_CALC);
    d.sby = (d.st == PPLC_STANDBY);
    d.run = d.act;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // All outputs straight from the state register
  assign o_freq_cmd    = q.freq;
  assign o_freq_step   = q.step;
  assign o_run         = q.run;
  assign o_loop_active = q.act;
  assign o_standby     = q.sby;
  assign o_upper_alarm = q.up_al;
  assign o_lower_alarm = q.lo_al;

endmodule : pplc_loop_ctrl

// File: testbench/pplc_loop_ctrl_monitor.sv
// Port-level checker for the process loop controller
`timescale 1ns/1ps
module pplc_loop_mon import pplc_pkg::*; #(
  parameter int          ADC_W       = 12,
  parameter int          FREQ_W      = 16,
  parameter int unsigned CALC_CYCLES = 500000
) (
  input wire logic              i_core_clk,
  input wire logic              i_rstn,
  input wire logic [1:0]        i_loop_enable_mode,
  input wire logic [1:0]        i_setpoint_source,
  input wire logic [1:0]        i_feedback_source,
  input wire logic [13:0]       i_digital_target,
  input wire logic [9:0]        i_upper_alarm_limit,
  input wire logic [9:0]        i_lower_alarm_limit,
  input wire logic [6:0]        i_max_step_increment,
  input wire logic [9:0]        i_wakeup_threshold,
  input wire logic [ADC_W-1:0]  i_voltage_analog_input,
  input wire logic [ADC_W-1:0]  i_current_analog_input,
  input wire logic              i_ext_start,
  input wire logic [FREQ_W-1:0] o_freq_cmd,
  input wire logic signed [FREQ_W:0] o_freq_step,
  input wire logic              o_run,
  input wire logic              o_loop_active,
  input wire logic              o_standby,
  input wire logic              o_upper_alarm,
  input wire logic              o_lower_alarm
);
  localparam int FS = 2**ADC_W - 1;
  int   fv, fc, fb, sp, stp, gap_q;
  logic up_c, lo_c, wake_c;
  logic [FREQ_W-1:0] prev_q;

  // Reference process values in 0.01 % of full scale
  always_comb begin
    fv = int'(i_voltage_analog_input) * 10000 / FS;
    fc = int'(i_current_analog_input) * 10000 / FS;
    case (i_feedback_source)
      2'h0: fb = fv;
      2'h1: fb = fc;
      2'h2: fb = fv - fc;
      default: fb = fc - fv;
    endcase
    case (i_setpoint_source)
      2'h1: sp = fv;
      2'h2: sp = fc;
      default: sp = int'(i_digital_target);
    endcase
    up_c = fb > 10 * int'(i_upper_alarm_limit);
    lo_c = fb < 10 * int'(i_lower_alarm_limit);
    wake_c = fb * 1000 < int'(i_wakeup_threshold) * sp;
    stp = (o_freq_step < 0) ? -int'(o_freq_step) : int'(o_freq_step);
  end

  // Cycles since the command last moved; spacing of computations
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q <= '0;
      gap_q  <= 0;
    end else begin
      prev_q <= o_freq_cmd;
      gap_q  <= (o_freq_cmd != prev_q) ? 0 : gap_q + 1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  property p_off;
    (i_loop_enable_mode == 2'h0) [*3] |-> !o_loop_active && !o_run;
  endproperty
  a_off: assert property (p_off)
    else $error("loop running while disabled");
  property p_ext;
    (i_loop_enable_mode == 2'h2 && !i_ext_start) [*8] |-> !o_loop_active;
  endproperty
  a_ext: assert property (p_ext)
    else $error("loop running without external start");
  property p_up;
    $past(i_rstn) |-> o_upper_alarm == $past(up_c);
  endproperty
  a_up: assert property (p_up)
    else $error("upper alarm wrong");
  property p_lo;
    $past(i_rstn) |-> o_lower_alarm == $past(lo_c);
  endproperty
  a_lo: assert property (p_lo)
    else $error("lower alarm wrong");
  property p_step;
    o_run |-> stp <= int'(i_max_step_increment);
  endproperty
  a_step: assert property (p_step)
    else $error("step above limit");
  property p_add;
    o_run && $past(o_run) && $changed(o_freq_cmd)
      |-> int'(o_freq_cmd) == int'($past(o_freq_cmd)) + int'(o_freq_step);
  endproperty
  a_add: assert property (p_add)
    else $error("command not moved by step");
  property p_gap;
    o_run && $past(o_run) && $changed(o_freq_cmd) |-> gap_q >= int'(CALC_CYCLES) - 1;
  endproperty
  a_gap: assert property (p_gap)
    else $error("computations too close");
  property p_sby;
    $rose(o_standby) |-> !o_run && o_freq_cmd == '0;
  endproperty
  a_sby: assert property (p_sby)
    else $error("standby with output running");
  property p_wake;
    o_standby && i_loop_enable_mode == 2'h1 && wake_c |=> !o_standby && o_loop_active;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake from standby");

  c_sby: cover property ($rose(o_standby));
  c_neg: cover property (o_run && o_freq_step < 0);
  c_alm: cover property (o_upper_alarm);
endmodule : pplc_loop_mon

bind pplc_loop_ctrl pplc_loop_mon #(
  .ADC_W(ADC_W),
  .FREQ_W(FREQ_W),
  .CALC_CYCLES(CALC_CYCLES)
) u_mon (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_loop_enable_mode(i_loop_enable_mode),
  .i_setpoint_source(i_setpoint_source), .i_feedback_source(i_feedback_source),
  .i_digital_target(i_digital_target), .i_upper_alarm_limit(i_upper_alarm_limit),
  .i_lower_alarm_limit(i_lower_alarm_limit), .i_max_step_increment(i_max_step_increment),
  .i_wakeup_threshold(i_wakeup_threshold), .i_voltage_analog_input(i_voltage_analog_input),
  .i_current_analog_input(i_current_analog_input), .i_ext_start(i_ext_start),
  .o_freq_cmd(o_freq_cmd), .o_freq_step(o_freq_step), .o_run(o_run),
  .o_loop_active(o_loop_active), .o_standby(o_standby), .o_upper_alarm(o_upper_alarm),
  .o_lower_alarm(o_lower_alarm));

// File: testbench/pplc_sensor.sv
// Process transmitter model feeding both analog input codes
`timescale 1ns/1ps
module pplc_sensor #(
  parameter int ADC_W = 12
) (
  input  wire logic             i_core_clk,
  input  wire logic [ADC_W-1:0] i_v_req,
  input  wire logic [ADC_W-1:0] i_c_req,
  output logic      [ADC_W-1:0] o_voltage,
  output logic      [ADC_W-1:0] o_current
);
  // Transmitter settles one clock after the process moves
  always_ff @(posedge i_core_clk) begin
    o_voltage <= i_v_req;
    o_current <= i_c_req;
  end
endmodule : pplc_sensor

// File: testbench/tb_pplc_loop_ctrl.sv
// Self-checking bench of the process loop controller
`timescale 1ns/1ps
module tb_pplc_loop_ctrl;
  import pplc_pkg::*;
  localparam int CC = 200;
  localparam int M  = 10;
  logic i_core_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic pol = 1'b0;
  logic ext = 1'b0;
  logic [1:0] mode = 2'h0, sps = 2'h0, fbs = 2'h0;
  logic [13:0] dig = 14'h0;
  logic [11:0] v_req = 12'h0, c_req = 12'h0, v_adc, c_adc, sdly = 12'h0;
  logic [9:0] lim_hi = 10'h384, lim_lo = 10'h064, wake = 10'h0;
  logic [6:0] mstep = 7'h0a;
  logic [11:0] pb = 12'h3e8, ti = 12'h003, td = 12'h000;
  logic [15:0] thr = 16'h0, cmd;
  logic signed [16:0] stp;
  logic run, act, sby, ual, lal;
  int fails = 0;
  int n_tests = 0;

  always #10 i_core_clk = ~i_core_clk;

  pplc_sensor sensor (.i_core_clk(i_core_clk), .i_v_req(v_req), .i_c_req(c_req),
    .o_voltage(v_adc), .o_current(c_adc));

  pplc_loop_ctrl #(.CALC_CYCLES(CC)) dut (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_loop_enable_mode(mode),
    .i_feedback_polarity(pol), .i_setpoint_source(sps), .i_feedback_source(fbs),
    .i_digital_target(dig), .i_upper_alarm_limit(lim_hi), .i_lower_alarm_limit(lim_lo),
    .i_proportional_band(pb), .i_integral_time(ti), .i_derivative_time(td),
    .i_max_step_increment(mstep), .i_standby_freq_threshold(thr), .i_standby_delay(sdly),
    .i_wakeup_threshold(wake), .i_max_freq(16'h1388), .i_voltage_analog_input(v_adc),
    .i_current_analog_input(c_adc), .i_ext_start(ext), .o_freq_cmd(cmd),
    .o_freq_step(stp), .o_run(run), .o_loop_active(act), .o_standby(sby),
    .o_upper_alarm(ual), .o_lower_alarm(lal));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask : cyc

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Fresh loop start, then exactly one computation is judged
  task automatic one_run(input logic p, input logic [1:0] s, input logic [1:0] f,
      input logic [13:0] d, input logic [11:0] v, input logic [11:0] c,
      input logic [31:0] e);
    mode <= 2'h0;
    cyc(4);
    pol <= p;
    sps <= s;
    fbs <= f;
    dig <= d;
    v_req <= v;
    c_req <= c;
    cyc(4);
    mode <= 2'h1;
    cyc(CC + 100);
    chk(32'(act), 32'h1);
    chk(32'(stp), e);
    chk({16'h0, cmd}, ($signed(e) > 0) ? e : 32'h0);
  endtask : one_run

  initial begin
    int i;
    cyc(4);
    i_rstn <= 1'b1;
    cyc(2);
    // Correction direction for each polarity, source and channel
    one_run(1'b0, 2'h0, 2'h0, 14'h1388, 12'h333, 12'h0, 32'(M));
    one_run(1'b1, 2'h0, 2'h0, 14'h1388, 12'h333, 12'h0, 32'(-M));
    one_run(1'b0, 2'h1, 2'h1, 14'h0, 12'hfff, 12'h333, 32'(M));
    one_run(1'b0, 2'h2, 2'h0, 14'h0, 12'hfff, 12'h333, 32'(-M));
    one_run(1'b0, 2'h0, 2'h2, 14'h1388, 12'hfff, 12'h333, 32'(-M));
    one_run(1'b0, 2'h0, 2'h3, 14'h1388, 12'hfff, 12'h333, 32'(M));
    // Loop gains on a small deviation, step limit raised so no clamping; then upper and lower alarms
    mstep <= 7'h64;
    one_run(1'b0, 2'h0, 2'h0, 14'h0032, 12'h0, 12'h0, 32'h19);
    pb <= 12'h1f4;
    one_run(1'b0, 2'h0, 2'h0, 14'h0032, 12'h0, 12'h0, 32'h33);
    pb <= 12'h3e8;
    td <= 12'h001;
    one_run(1'b0, 2'h0, 2'h0, 14'h0032, 12'h0, 12'h0, 32'h32);
    td <= 12'h000;
    ti <= 12'h001;
    one_run(1'b0, 2'h0, 2'h0, 14'h0032, 12'h0, 12'h0, 32'h1b);
    one_run(1'b0, 2'h0, 2'h0, 14'h2710, 12'hfff, 12'h0, 32'h0);
    chk(32'(ual), 32'h1);
    v_req <= 12'h0;
    cyc(4);
    chk(32'(lal), 32'h1);
    chk(32'(ual), 32'h0);
    // External start gating
    mode <= 2'h2;
    cyc(20);
    chk(32'(act), 32'h0);
    ext <= 1'b1;
    cyc(10);
    chk(32'(act), 32'h1);
    ext <= 1'b0;
    cyc(10);
    chk(32'(act), 32'h0);
    mode <= 2'h0;
    cyc(5);
    chk(32'(act), 32'h0);
    // Standby entry with the command pinned low, then wake
    pol <= 1'b1;
    fbs <= 2'h0;
    sps <= 2'h0;
    dig <= 14'h1388;
    // Feedback between wake level and set point: below set point pins the command at 0, below wake level standby ends at once
    v_req <= 12'h733;
    thr <= 16'h03e8;
    wake <= 10'h320;
    cyc(4);
    mode <= 2'h1;
    for (i = 0; i < 15 * CC && sby !== 1'b1; i++)
      cyc(1);
    chk(32'(sby), 32'h1);
    chk(32'(i > 9 * CC), 32'h1);
    chk(32'(run), 32'h0);
    chk({16'h0, cmd}, 32'h0);
    v_req <= 12'h999;
    cyc(20);
    chk(32'(sby), 32'h1);
    v_req <= 12'h666;
    cyc(20);
    chk(32'(sby), 32'h1);
    v_req <= 12'h63d;
    cyc(5);
    chk(32'(sby), 32'h0);
    chk(32'(act), 32'h1);
    print_verdict();
  end

  // Hang guard well beyond the expected run length
  initial begin
    cyc(20000);
    fails++;
    print_verdict();
  end
endmodule : tb_pplc_loop_ctrl
